//--- spi_nvm_slave.v
/*
  serial slave command decoder for a 16k x 8 nonvolatile memory.
  assumes a host master drives cs_n, sck, si and wp_n; all are sampled by
  clock, which must run well above four times the serial clock.
*/
// What this block does
// RULE1: acts only as serial slave; sck and cs_n are inputs only.
// RULE2: status bit 7 protect enable, written and read by status commands.
// RULE3: status bits 6..4 are plain storage, written and read back.
// RULE4: status bits 3..2 are block-protect bits, written and read.
// RULE5: status bit 1 shows the latch; status write cannot change it.
// RULE6: latch clears at reset and clear command; survives write commands.
// RULE7: status bit 0 always reads zero.
// RULE8: eight op-codes decoded; host sends no other value.
// RULE9: cs_n rising mid op-code executes nothing.
// RULE10: op-code 06h sets the latch.
// RULE11: op-code 04h clears latch; writes without latch do nothing.
// RULE12: op-code 05h streams status on falling edges, repeating.
// RULE13: op-code 01h writes status; bits 1 and 0 ignored.
// RULE14: host holds wp_n steady through a status write.
// RULE15: op-code 03h, 16-bit address, top two bits ignored, data out.
// RULE16: memory read increments and wraps the address per byte.
// RULE17: op-code 02h commits each byte on its eighth bit.
// RULE18: memory write increments and wraps the address per byte.
// RULE19: op-code 9fh shifts 32 identity bits, msb byte first.
// RULE20: after 32 identity bits the last bit stays on so.
// RULE21: op-code b9h sleeps at cs_n rise unless an sck rise came.
// RULE22: protect pair selects none, 3000h+, 2000h+, or all.
// RULE23: no latch blocks all writes; protect rules for status.
// RULE24: only clock modes 0 and 3 supported.
// RULE25: cs_n high resets decoder and tristates so.
// RULE26: a partial trailing write byte commits nothing.
`timescale 1ns/100ps
`include "spi_nvm_consts.vh"
module spi_nvm_slave
#(
  parameter [31:0] IDENTITY = 32'h5a_7f_12_34 // arbitrary value
)
(
  input  wire       clock,
  input  wire       sys_rst,
  input  wire       cs_n,
  input  wire       sck,
  input  wire       si,
  input  wire       wp_n,
  output reg        so,
  output reg        so_oe,
  output reg  [7:0] status_out,
  output reg        sleeping
);
  localparam [6:0] S_OPCODE = 7'h01;
  localparam [6:0] S_ADDR   = 7'h02;
  localparam [6:0] S_RDATA  = 7'h04;
  localparam [6:0] S_WDATA  = 7'h08;
  localparam [6:0] S_STOUT  = 7'h10;
  localparam [6:0] S_STIN   = 7'h20;
  localparam [6:0] S_IDOUT  = 7'h40;

  reg [7:0] mem [0:`MEM_WORDS-1];

  wire      cs_s;
  wire      sck_s;
  wire      si_s;
  wire      wp_s;
  reg       sck_q;
  reg       cs_q;
  wire      rise;
  wire      fall;
  wire      cs_end;

  reg [6:0]  state_q;
  reg [4:0]  bit_q;
  reg [15:0] shin_q;
  reg [31:0] shout_q;
  reg [13:0] addr_q;
  reg        wel_q;
  reg        rd_q;         // address phase belongs to a memory read
  reg [5:0]  st_q;         // status bits 7..2
  reg        sleep_arm_q;
  reg        sleep_q;
  reg        fifo_busy_q;

  wire [7:0]  status_val;
  wire [7:0]  nxt_byte;
  reg  [21:0] wr_in_q;
  wire        commit;
  wire        wr_in_ready;
  wire [21:0] wr_out;
  wire        wr_out_valid;

  // protected range check for a memory address
  function is_protected;
    input [1:0]  bp;
    input [13:0] a;
    begin
      case (bp)
        2'b01:   is_protected = (a >= `ADDR_QUARTER); // see RULE22
        2'b10:   is_protected = (a >= `ADDR_HALF);
        2'b11:   is_protected = 1'b1;
        default: is_protected = 1'b0;
      endcase
    end
  endfunction

  // pin synchronisers (three stages each); sck is only ever sampled, see RULE1
  pin_sync #(.RST_VAL(1'b1)) u_cs  (.clock(clock), .sys_rst(sys_rst), .din(cs_n), .dout(cs_s));
  pin_sync #(.RST_VAL(1'b0)) u_sck (.clock(clock), .sys_rst(sys_rst), .din(sck),  .dout(sck_s));
  pin_sync #(.RST_VAL(1'b0)) u_si  (.clock(clock), .sys_rst(sys_rst), .din(si),   .dout(si_s));
  pin_sync #(.RST_VAL(1'b1)) u_wp  (.clock(clock), .sys_rst(sys_rst), .din(wp_n), .dout(wp_s));

  // edge finding on the filtered clock and select
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      sck_q <= 1'b0;
      cs_q  <= 1'b1;
    end
    else
    begin
      sck_q <= sck_s;
      cs_q  <= cs_s;
    end
  end

  // sampling on rise, shifting on fall covers modes 0 and 3 alike
  assign rise   = sck_s & ~sck_q & ~cs_s; // see RULE24
  assign fall   = ~sck_s & sck_q & ~cs_s;
  assign cs_end = cs_s & ~cs_q;

  // status as read: bit 0 fixed low, bit 1 the latch
  assign status_val = {st_q[5:0], wel_q, 1'b0}; // see RULE5, see RULE7
  assign nxt_byte   = {shin_q[6:0], si_s};

  // a write byte is complete on its eighth rise; latch and protect ranges decide
  assign commit = rise & ~sleep_q & (state_q == S_WDATA) & (bit_q[2:0] == 3'h7) &
                  wel_q & ~is_protected(st_q[1:0], addr_q) &           // see RULE17, see RULE23, see RULE11
                  wr_in_ready;

  // write request register: address and byte held for one push into the fifo
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      fifo_busy_q <= 1'b0;
      wr_in_q     <= {22{1'b0}};
    end
    else
    begin
      fifo_busy_q <= commit;
      if (commit)
        wr_in_q <= {addr_q, nxt_byte};
    end
  end

  byte_fifo #(.WIDTH(22), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo
  (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_data   (wr_in_q),
    .in_valid  (fifo_busy_q),
    .in_ready  (wr_in_ready),
    .out_data  (wr_out),
    .out_valid (wr_out_valid),
    .out_ready (1'b1)
  );

  // array write port drains the fifo
  always @(posedge clock)
  begin
    if (wr_out_valid)
      mem[wr_out[21:8]] <= wr_out[7:0];
  end

  // command decoder
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_q     <= S_OPCODE;
      bit_q       <= 5'h00;
      shin_q      <= 16'h0000;
      shout_q     <= 32'h00000000;
      addr_q      <= 14'h0000;
      wel_q       <= 1'b0;                  // see RULE6
      st_q        <= `ST_NV_RESET;
      sleep_arm_q <= 1'b0;
      sleep_q     <= 1'b0;
      so          <= 1'b0;
      so_oe       <= 1'b0;
      rd_q        <= 1'b0;
    end
    else if (cs_s)
    begin
      // deselect: back to op-code, output released
      state_q     <= S_OPCODE;              // see RULE25, see RULE9, see RULE26
      bit_q       <= 5'h00;
      so_oe       <= 1'b0;
      if (cs_end & sleep_arm_q)
        sleep_q   <= 1'b1;                  // see RULE21
      sleep_arm_q <= 1'b0;
    end
    else if (sleep_q)
    begin
      // wake on select; pins ignored only in the first selected cycle
      if (~cs_q)
        sleep_q <= sleep_q;
      if (cs_q)
        sleep_q <= 1'b0;
      state_q <= S_OPCODE;
      so_oe   <= 1'b0;
    end
    else
    begin
      // only a new rise cancels; the mode 0 closing fall is part of the op-code
      if (rise)
        sleep_arm_q <= 1'b0;                // see RULE21
      if (rise)
      begin
        shin_q <= {shin_q[14:0], si_s};
        bit_q  <= bit_q + 5'h01;
        case (state_q)
          S_OPCODE:
          begin
            if (bit_q == 5'h07)
            begin
              bit_q <= 5'h00;
              case (nxt_byte)               // see RULE8
                `OP_SET_LATCH:    wel_q <= 1'b1;          // see RULE10
                `OP_CLEAR_LATCH:  wel_q <= 1'b0;          // see RULE11
                `OP_STATUS_READ:
                begin
                  state_q <= S_STOUT;
                  shout_q <= {status_val, 24'h000000};
                end
                `OP_STATUS_WRITE: state_q <= S_STIN;
                `OP_MEM_READ,
                `OP_MEM_WRITE:
                begin
                  // remember which of the two owns the address phase
                  state_q <= S_ADDR;
                  rd_q    <= (nxt_byte == `OP_MEM_READ);
                end
                `OP_IDENTITY_READ:
                begin
                  state_q <= S_IDOUT;
                  shout_q <= IDENTITY;    // see RULE19
                end
                `OP_SLEEP:        sleep_arm_q <= 1'b1;
                default:          state_q <= S_OPCODE;
              endcase
            end
          end
          S_ADDR:
          begin
            if (bit_q == 5'h0f)
            begin
              bit_q   <= 5'h00;
              addr_q  <= {shin_q[12:0], si_s}; // see RULE15
              if (rd_q)
              begin
                state_q <= S_RDATA;
                shout_q <= {mem[{shin_q[12:0], si_s}], 24'h000000};
              end
              else
                state_q <= S_WDATA;
            end
          end
          S_WDATA:
          begin
            if (bit_q[2:0] == 3'h7)
            begin
              bit_q <= 5'h00;
              // the byte itself leaves through commit; step to the next address
              addr_q <= addr_q + 14'h0001;  // see RULE18
            end
          end
          S_STIN:
          begin
            if (bit_q[2:0] == 3'h7)
            begin
              state_q <= S_OPCODE;
              bit_q   <= 5'h00;
              if (wel_q & ~(st_q[5] & ~wp_s)) // see RULE23, see RULE14
                st_q <= nxt_byte[7:2];      // see RULE2, see RULE3, see RULE4, see RULE13
            end
          end
          default:
          begin
            if (bit_q[2:0] == 3'h7)
              bit_q <= 5'h00;
          end
        endcase
      end
      else if (fall)
      begin
        case (state_q)
          S_STOUT:
          begin
            so      <= shout_q[31];         // see RULE12
            so_oe   <= 1'b1;
            shout_q <= (bit_q == 5'h07) ? {status_val, 24'h000000} : {shout_q[30:0], 1'b0};
          end
          S_RDATA:
          begin
            so    <= shout_q[31];           // see RULE16
            so_oe <= 1'b1;
            if (bit_q == 5'h07)
            begin
              shout_q <= {mem[addr_q + 14'h0001], 24'h000000};
              addr_q  <= addr_q + 14'h0001;
            end
            else
              shout_q <= {shout_q[30:0], 1'b0};
          end
          S_IDOUT:
          begin
            so      <= shout_q[31];
            so_oe   <= 1'b1;
            if (shout_q[30:0] != 31'h0 || bit_q != 5'h00)
              shout_q <= {shout_q[30:0], shout_q[0]}; // see RULE20
          end
          default:
            so_oe <= so_oe;
        endcase
      end
    end
  end

  // visible status and sleep state
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      status_out <= 8'h00;
      sleeping   <= 1'b0;
    end
    else
    begin
      status_out <= status_val;
      sleeping   <= sleep_q;
    end
  end
endmodule // spi_nvm_slave

//--- spi_nvm_consts.vh
/*
  constants for the serial nonvolatile memory command decoder:
  op-codes, status field positions, protect range bounds and sizes.
  assumes inclusion by bare name from the design files.
*/
`ifndef SPI_NVM_CONSTS_VH
`define SPI_NVM_CONSTS_VH

`define OP_SET_LATCH      8'h06
`define OP_CLEAR_LATCH    8'h04
`define OP_STATUS_READ    8'h05
`define OP_STATUS_WRITE   8'h01
`define OP_MEM_READ       8'h03
`define OP_MEM_WRITE      8'h02
`define OP_IDENTITY_READ  8'h9f
`define OP_SLEEP          8'hb9

`define ST_PROTECT_EN     7
`define ST_SPARE_HI       6
`define ST_SPARE_LO       4
`define ST_BP_HIGH        3
`define ST_BP_LOW         2
`define ST_WEL            1
`define ST_ZERO           0

`define STATUS_RESET      8'h00
`define ST_NV_RESET       6'h00
`define ADDR_BITS         14
`define MEM_WORDS         16384
`define ADDR_QUARTER      14'h3000
`define ADDR_HALF         14'h2000
`define FIFO_DEPTH        8
`define FIFO_AW           3

`endif

//--- pin_sync.v
/*
  three-stage synchroniser for an asynchronous pin, with agreement filter.
  assumes clock is the block clock and din comes from outside its domain.
*/
`timescale 1ns/100ps
module pin_sync
#(
  parameter RST_VAL = 1'b0
)
(
  input  wire clock,
  input  wire sys_rst,
  input  wire din,
  output reg  dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // chain; change accepted once stages two and three agree
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        dout <= s3_q;
    end
  end
endmodule // pin_sync

//--- byte_fifo.v
/*
  synchronous fifo with valid/ready on both sides.
  assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/100ps
module byte_fifo
#(
  parameter WIDTH = 22,
  parameter DEPTH = 8,
  parameter AW    = 3
)
(
  input  wire             clock,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_q;
  reg [AW-1:0]    rp_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH);
  assign out_valid = (cnt_q != 0);
  assign out_data  = mem[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage
  always @(posedge clock)
  begin
    if (push)
      mem[wp_q] <= in_data;
  end

  // pointers and fill count
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // byte_fifo

//--- spi_nvm_properties.sv
/* timing checks on the serial memory slave ports.
   assumes binding onto spi_nvm_slave, one clock domain. */
`timescale 1ns/100ps
module spi_nvm_properties
(
  input wire       clock,
  input wire       sys_rst,
  input wire       cs_n,
  input wire       wp_n,
  input wire       so_oe,
  input wire [7:0] status_out,
  input wire       sleeping
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // output and status behaviour around selection
  oe_release_a: assert property (cs_n [*8] |-> !so_oe)
    else $error("so_oe high while deselected");
  zero_bit_a: assert property (!status_out[0])
    else $error("status bit 0 not zero");
  idle_status_a: assert property (cs_n [*8] |=> $stable(status_out))
    else $error("status moved while deselected");
  latch_gate_a: assert property ($changed(status_out[7:2]) |-> $past(status_out[1]))
    else $error("status written without latch");
  wp_gate_a: assert property ($changed(status_out[7:2]) |-> $past(wp_n) || !$past(status_out[7]))
    else $error("status written while protected");
  sleep_quiet_a: assert property (sleeping [*3] |-> !so_oe)
    else $error("so driven while asleep");
  sleep_entry_a: assert property ($rose(sleeping) |-> cs_n && $past(cs_n, 2))
    else $error("sleep entered while selected");
  drive_select_a: assert property ($rose(so_oe) |-> !$past(cs_n, 3))
    else $error("so driven without select");

  // main scenarios reached
  status_chg_c: cover property ($changed(status_out[7:2]));
  sleep_c: cover property ($rose(sleeping));
  drive_c: cover property ($rose(so_oe));
endmodule // spi_nvm_properties

bind spi_nvm_slave spi_nvm_properties chk (.clock(clock), .sys_rst(sys_rst), .cs_n(cs_n),
  .wp_n(wp_n), .so_oe(so_oe), .status_out(status_out), .sleeping(sleeping));

//--- spi_host_model.sv
/* serial host master model, clock modes 0 and 3, msb first.
   assumes clock is the bench clock; sck half period is 4 clocks. */
`timescale 1ns/100ps
module spi_host_model
(
  input  wire  clock,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic wp_n,
  input  wire  so
);
  logic [7:0] txb [0:7];
  logic [7:0] rxb [0:7];
  logic       cpol;

  // idle pins at time zero
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    wp_n = 1'b1;
    cpol = 1'b0;
    foreach (txb[k]) txb[k] = 8'h00;
  end

  // clock idle level and protect pin, changed only between frames
  task automatic set_pins(input logic pol, input logic wp);
    begin
      cpol = pol;
      sck = pol;
      wp_n = wp;
    end
  endtask

  // one frame; only valid op-codes are queued, wp_n moves between frames
  task automatic xfer(input int nbits);
    int i;
    begin
      @(negedge clock);
      cs_n = 1'b0;
      repeat (4) @(negedge clock);
      for (i = 0; i < nbits; i++)
      begin
        sck = 1'b0;
        si = txb[i/8][7-i%8];
        repeat (4) @(negedge clock);
        sck = 1'b1;
        repeat (4) @(negedge clock);
        rxb[i/8][7-i%8] = so;
      end
      sck = cpol;
      si = ~si; // released line does not keep its value
      repeat (2) @(negedge clock);
      cs_n = 1'b1;
      repeat (12) @(negedge clock);
    end
  endtask
endmodule // spi_host_model

//--- tb_top.sv
/* self-checking bench for the serial memory slave.
   assumes the host model and the bound property checker. */
`timescale 1ns/100ps
module tb_top;
  localparam logic [31:0] ID_VAL = 32'hc3_81_4e_27; // arbitrary value
  logic       clock;
  logic       sys_rst;
  wire        cs_n, sck, si, wp_n, so, so_oe, sleeping;
  wire  [7:0] status_out;
  wire        so_bus;

  // a released so line shows the inverse of its last value
  assign so_bus = so_oe ? so : ~so;
  int         err_total, n_tests, cyc;

  spi_host_model host (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so_bus));
  spi_nvm_slave #(.IDENTITY(ID_VAL)) dut (.clock(clock), .sys_rst(sys_rst), .cs_n(cs_n),
    .sck(sck), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe), .status_out(status_out),
    .sleeping(sleeping));

  // 50 mhz clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic complete_run;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_tests++;
      if (got !== exp)
      begin
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        err_total++;
      end
    end
  endtask

  task automatic cmd(input logic [7:0] b0, b1, b2, b3, input int nbits);
    begin
      host.txb[0] = b0;
      host.txb[1] = b1;
      host.txb[2] = b2;
      host.txb[3] = b3;
      host.xfer(nbits);
    end
  endtask

  // latch set, clear and abort
  task automatic t_latch;
    begin
      cmd(8'h01, 8'h8c, 8'h00, 8'h00, 16);
      chk(status_out, 8'h00);
      cmd(8'h06, 8'h00, 8'h00, 8'h00, 5);
      chk(status_out, 8'h00);
      cmd(8'h06, 8'h00, 8'h00, 8'h00, 8);
      chk(status_out, 8'h02);
      cmd(8'h05, 8'h00, 8'h00, 8'h00, 24);
      chk({host.rxb[1], host.rxb[2]}, 16'h0202);
      cmd(8'h04, 8'h00, 8'h00, 8'h00, 8);
      chk(status_out, 8'h00);
    end
  endtask

  // status write, read back, pin protection
  task automatic t_status;
    begin
      cmd(8'h06, 8'h00, 8'h00, 8'h00, 8);
      cmd(8'h01, 8'hff, 8'h00, 8'h00, 16);
      chk(status_out, 8'hfe);
      cmd(8'h05, 8'h00, 8'h00, 8'h00, 16);
      chk(host.rxb[1], 8'hfe);
      host.set_pins(1'b0, 1'b0);
      cmd(8'h01, 8'h00, 8'h00, 8'h00, 16);
      chk(status_out, 8'hfe);
      host.set_pins(1'b0, 1'b1);
      cmd(8'h01, 8'h00, 8'h00, 8'h00, 16);
      chk(status_out, 8'h02);
    end
  endtask

  // wrap, partial byte, block protect, no latch
  task automatic t_mem;
    begin
      host.txb[4] = 8'h22;
      cmd(8'h02, 8'hff, 8'hff, 8'h11, 40);
      cmd(8'h03, 8'h3f, 8'hff, 8'h00, 48);
      chk({host.rxb[3], host.rxb[4]}, 16'h1122);
      host.txb[4] = 8'h3c;
      cmd(8'h02, 8'h00, 8'h10, 8'h3c, 40);
      host.txb[4] = 8'hc3;
      cmd(8'h02, 8'h00, 8'h10, 8'h5a, 36);
      cmd(8'h03, 8'h00, 8'h10, 8'h00, 40);
      chk({host.rxb[3], host.rxb[4]}, 16'h5a3c);
      cmd(8'h01, 8'h04, 8'h00, 8'h00, 16);
      host.txb[4] = 8'h77;
      cmd(8'h02, 8'h2f, 8'hff, 8'h66, 40);
      cmd(8'h03, 8'h2f, 8'hff, 8'h00, 40);
      chk(host.rxb[3], 8'h66);
      chk(host.rxb[4] === 8'h77, 1'b0);
      cmd(8'h04, 8'h00, 8'h00, 8'h00, 8);
      cmd(8'h02, 8'h00, 8'h10, 8'hee, 32);
      cmd(8'h03, 8'h00, 8'h10, 8'h00, 32);
      chk(host.rxb[3], 8'h5a);
    end
  endtask

  // identity and sleep in clock mode 3
  task automatic t_ident;
    begin
      host.set_pins(1'b1, 1'b1);
      cmd(8'h9f, 8'h00, 8'h00, 8'h00, 48);
      chk({host.rxb[1], host.rxb[2], host.rxb[3], host.rxb[4]}, ID_VAL);
      chk(host.rxb[5], {8{ID_VAL[0]}});
      cmd(8'hb9, 8'h00, 8'h00, 8'h00, 8);
      chk({sleeping, so_oe}, 2'b10);
      cmd(8'h05, 8'h00, 8'h00, 8'h00, 8);
      chk(sleeping, 1'b0);
    end
  endtask

  // reset, then each scenario
  initial
  begin
    sys_rst = 1'b1;
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    repeat (8) @(negedge clock);
    chk({status_out, so_oe}, 9'h000);
    t_latch();
    t_status();
    t_mem();
    t_ident();
    complete_run();
  end
endmodule // tb_top
